// >>> logic/cpsc_pkg.sv
// Package with constants and types for the channel pin status control block
package cpsc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STATUS     = 8'h04;
  localparam logic [7:0] OFF_INT_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_CLEAR  = 8'h0C;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h10;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       datapathReset;  // Bit 8, self-clearing
    logic [1:0] serRatio;       // Bits 7:6
    logic [1:0] losSelect;      // Bits 5:4
    logic       losEnable;      // Bit 3
    logic       pdRegB;         // Bit 2
    logic       pdRegA;         // Bit 1
    logic       routeAtoB;      // Bit 0
  } cpsc_ctrl_t;

  // One output pin or pair: level, and drive high while the pin is driven
  typedef struct packed {
    logic level;
    logic drive;
  } cpsc_pin_t;

  localparam int CTRL_W = 9;
  localparam cpsc_ctrl_t CTRL_RESET = 9'h0C8;  // 4:1, loss detect on, state shown

  // Serialization ratio codes; 2'h3 behaves as 4:1
  localparam logic [1:0] RATIO_1TO1 = 2'h0;
  localparam logic [1:0] RATIO_2TO1 = 2'h1;
  localparam logic [1:0] RATIO_4TO1 = 2'h2;

  // What the loss-of-signal pin shows
  localparam logic [1:0] LOSSEL_STATE   = 2'h0;
  localparam logic [1:0] LOSSEL_PARTNER = 2'h1;
  localparam logic [1:0] LOSSEL_LOCAL   = 2'h2;
  localparam logic [1:0] LOSSEL_PENDING = 2'h3;

  // Interrupt bit positions
  localparam int INT_W         = 4;
  localparam int INT_LOS_SET   = 0;
  localparam int INT_LOS_CLR   = 1;
  localparam int INT_ALIGN_CHG = 2;
  localparam int INT_POWER_UP  = 3;

  // Synchroniser bit positions
  localparam int SYNC_W       = 5;
  localparam int SYNC_PD_A    = 0;
  localparam int SYNC_PD_B    = 1;
  localparam int SYNC_PARTNER = 2;
  localparam int SYNC_CLK_A   = 3;
  localparam int SYNC_CLK_B   = 4;
  localparam logic [4:0] SYNC_RESET = 5'h03;  // Power-down pins idle high

  // Receive swing thresholds, unit 1 mVpp: 75 mVpp and 150 mVpp
  localparam logic [7:0] LOS_LOW_MVPP  = 8'h4B;
  localparam logic [7:0] LOS_HIGH_MVPP = 8'h96;

endpackage : cpsc_pkg

// >>> logic/cpsc_channel_pin_status_control.sv
// Pin state, clock routing, alignment status and loss-of-signal control of one channel
`timescale 1ns/1ps
module cpsc_channel_pin_status_control #(
  parameter int ADDR_W = 8,
  parameter int LANES  = 4
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  // Pins from outside the clock domain
  input  wire logic                   chanAPowerdownLow,
  input  wire logic                   chanBPowerdownLow,
  input  wire logic                   partnerRxAlignedIn,
  input  wire logic                   chanAByteClock,
  input  wire logic                   chanBByteClock,
  // On-chip datapath, same clock
  input  wire logic [LANES-1:0]       lsParallelInLanes,
  input  wire logic                   hsSerialRxBit,
  input  wire logic [7:0]             rxSwingMvpp,
  input  wire logic                   txLanesAligned,
  // Output pins
  output cpsc_pkg::cpsc_pin_t         chanAClockOutPair,
  output cpsc_pkg::cpsc_pin_t         chanBClockOutPair,
  output logic                        hsSerialTxPos,
  output logic      [LANES-1:0]       lsParallelOutLanes,
  output cpsc_pkg::cpsc_pin_t         signalLostIndicator,
  output logic                        localTxAlignedOut,
  output logic                        datapathResetPulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [cpsc_pkg::SYNC_W-1:0] syncMeta_reg,  syncMeta_next;
  logic [cpsc_pkg::SYNC_W-1:0] syncPin_reg,   syncPin_next;
  cpsc_pkg::cpsc_ctrl_t        ctrl_reg,      ctrl_next;
  logic [cpsc_pkg::INT_W-1:0]  intStatus_reg, intStatus_next;
  logic [cpsc_pkg::INT_W-1:0]  intEnable_reg, intEnable_next;
  logic                        losState_reg,  losState_next;
  logic                        prevLos_reg,   prevLos_next;
  logic                        prevAlign_reg, prevAlign_next;
  logic                        prevDown_reg,  prevDown_next;
  logic                        pending_reg,   pending_next;
  logic [1:0]                  txIdx_reg,     txIdx_next;
  logic [1:0]                  rxIdx_reg,     rxIdx_next;
  cpsc_pkg::cpsc_pin_t         clkA_reg,      clkA_next;
  cpsc_pkg::cpsc_pin_t         clkB_reg,      clkB_next;
  cpsc_pkg::cpsc_pin_t         losPin_reg,    losPin_next;
  logic                        hsTx_reg,      hsTx_next;
  logic [LANES-1:0]            lsOut_reg,     lsOut_next;
  logic                        txAlign_reg,   txAlign_next;
  logic                        dpReset_reg,   dpReset_next;
  logic                        irq_reg,       irq_next;
  logic [31:0]                 prdata_reg,    prdata_next;
  logic                        pready_reg,    pready_next;
  logic                        pslverr_reg,   pslverr_next;

  logic                        chanDown;
  logic                        bothDown;
  logic                        partnerAligned;
  logic [LANES-1:0]            laneMask;
  logic [2:0]                  laneCount;
  logic [1:0]                  txSel;
  logic [1:0]                  rxSel;
  logic                        wrDone;
  logic                        rdSetup;
  logic                        addrHit;
  logic [cpsc_pkg::INT_W-1:0]  events;
  logic [cpsc_pkg::INT_W-1:0]  clearMask;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    // Both pin and register power-down count for this channel
    chanDown       = !syncPin_reg[cpsc_pkg::SYNC_PD_A] || ctrl_reg.pdRegA;
    bothDown       = chanDown && (!syncPin_reg[cpsc_pkg::SYNC_PD_B] || ctrl_reg.pdRegB);
    partnerAligned = syncPin_reg[cpsc_pkg::SYNC_PARTNER];

    // Lane usage per ratio; any code other than 1:1 and 2:1 uses every lane
    case (ctrl_reg.serRatio)
      cpsc_pkg::RATIO_1TO1: begin
        laneCount = 3'h1;
      end
      cpsc_pkg::RATIO_2TO1: begin
        laneCount = 3'h2;
      end
      default: begin
        laneCount = 3'h4;
      end
    endcase
    for (int i = 0; i < LANES; i++) begin
      laneMask[i] = (i < int'(laneCount));
    end
    // A stale index after a ratio change falls back to lane 0
    txSel = ({1'b0, txIdx_reg} < laneCount) ? txIdx_reg : 2'h0;
    rxSel = ({1'b0, rxIdx_reg} < laneCount) ? rxIdx_reg : 2'h0;

    syncMeta_next = {chanBByteClock, chanAByteClock, partnerRxAlignedIn, chanBPowerdownLow, chanAPowerdownLow};
    syncPin_next  = syncMeta_reg;

    // Loss of signal with hysteresis; between thresholds the state holds
    losState_next = losState_reg;
    if (!ctrl_reg.losEnable) begin
      losState_next = 1'b0;
    end else if (rxSwingMvpp < cpsc_pkg::LOS_LOW_MVPP) begin
      losState_next = 1'b1;
    end else if (rxSwingMvpp > cpsc_pkg::LOS_HIGH_MVPP) begin
      losState_next = 1'b0;
    end

    // Serializer and deserializer lane walk
    txIdx_next = ({1'b0, txSel} + 3'h1 >= laneCount) ? 2'h0 : 2'(txSel + 2'h1);
    rxIdx_next = ({1'b0, rxSel} + 3'h1 >= laneCount) ? 2'h0 : 2'(rxSel + 2'h1);
    hsTx_next  = lsParallelInLanes[txSel] && laneMask[txSel];
    lsOut_next = lsOut_reg;
    lsOut_next[rxSel] = hsSerialRxBit;
    lsOut_next = lsOut_next & laneMask;
    if (chanDown) begin
      hsTx_next  = 1'b0;
      lsOut_next = '0;
      txIdx_next = 2'h0;
      rxIdx_next = 2'h0;
    end
    txAlign_next = txLanesAligned && !chanDown;

    // Output clock pairs
    clkA_next.level = syncPin_reg[cpsc_pkg::SYNC_CLK_A] && !bothDown;
    clkA_next.drive = !bothDown;
    clkB_next.level = (ctrl_reg.routeAtoB ? syncPin_reg[cpsc_pkg::SYNC_CLK_A]
                                          : syncPin_reg[cpsc_pkg::SYNC_CLK_B]) && !bothDown;
    clkB_next.drive = !bothDown;

    // Loss pin shows the state or another chosen function, registered one clock after its source
    case (ctrl_reg.losSelect)
      cpsc_pkg::LOSSEL_STATE: begin
        losPin_next.level = losState_reg;
      end
      cpsc_pkg::LOSSEL_PARTNER: begin
        losPin_next.level = partnerAligned;
      end
      cpsc_pkg::LOSSEL_LOCAL: begin
        losPin_next.level = txAlign_reg;
      end
      default: begin
        losPin_next.level = pending_reg;
      end
    endcase
    losPin_next.drive = !chanDown;
    if (chanDown) begin
      losPin_next.level = 1'b0;
    end

    // APB access: two-cycle access phase, write lands when pready is seen
    rdSetup = psel && !penable;
    wrDone  = psel && penable && pready_reg && pwrite;
    addrHit = (paddr == ADDR_W'(cpsc_pkg::OFF_CTRL)) || (paddr == ADDR_W'(cpsc_pkg::OFF_STATUS)) ||
              (paddr == ADDR_W'(cpsc_pkg::OFF_INT_STATUS)) || (paddr == ADDR_W'(cpsc_pkg::OFF_INT_CLEAR)) ||
              (paddr == ADDR_W'(cpsc_pkg::OFF_INT_ENABLE));
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !addrHit;
    prdata_next  = prdata_reg;
    if (rdSetup) begin
      prdata_next = 32'h0000_0000;
      if (paddr == ADDR_W'(cpsc_pkg::OFF_CTRL)) begin
        prdata_next[cpsc_pkg::CTRL_W-1:0] = {1'b0, ctrl_reg[cpsc_pkg::CTRL_W-2:0]};
      end else if (paddr == ADDR_W'(cpsc_pkg::OFF_STATUS)) begin
        prdata_next[5:0] = {pending_reg, bothDown, chanDown, txAlign_reg, partnerAligned, losState_reg};
      end else if (paddr == ADDR_W'(cpsc_pkg::OFF_INT_STATUS)) begin
        prdata_next[cpsc_pkg::INT_W-1:0] = intStatus_reg;
      end else if (paddr == ADDR_W'(cpsc_pkg::OFF_INT_ENABLE)) begin
        prdata_next[cpsc_pkg::INT_W-1:0] = intEnable_reg;
      end
    end

    ctrl_next = ctrl_reg;
    ctrl_next.datapathReset = 1'b0;
    if (wrDone && paddr == ADDR_W'(cpsc_pkg::OFF_CTRL)) begin
      ctrl_next = cpsc_pkg::cpsc_ctrl_t'(pwdata[cpsc_pkg::CTRL_W-1:0]);
    end
    dpReset_next = ctrl_reg.datapathReset;
    intEnable_next = intEnable_reg;
    if (wrDone && paddr == ADDR_W'(cpsc_pkg::OFF_INT_ENABLE)) begin
      intEnable_next = pwdata[cpsc_pkg::INT_W-1:0];
    end

    // Events; a set in the cycle of a clear wins
    prevLos_next   = losState_reg;
    prevAlign_next = partnerAligned;
    prevDown_next  = chanDown;
    events = '0;
    events[cpsc_pkg::INT_LOS_SET]   = losState_reg && !prevLos_reg;
    events[cpsc_pkg::INT_LOS_CLR]   = !losState_reg && prevLos_reg;
    events[cpsc_pkg::INT_ALIGN_CHG] = partnerAligned != prevAlign_reg;
    events[cpsc_pkg::INT_POWER_UP]  = prevDown_reg && !chanDown;
    clearMask = '0;
    if (wrDone && paddr == ADDR_W'(cpsc_pkg::OFF_INT_CLEAR)) begin
      clearMask = pwdata[cpsc_pkg::INT_W-1:0];
    end
    intStatus_next = (intStatus_reg & ~clearMask) | events;
    irq_next = |(intStatus_next & intEnable_next);

    // Channel waits for a host datapath reset after leaving power-down
    pending_next = pending_reg;
    if (ctrl_reg.datapathReset) begin
      pending_next = 1'b0;
    end
    if (events[cpsc_pkg::INT_POWER_UP]) begin
      pending_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers; reset drives pins to zero, loss pin driven low
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta_reg  <= cpsc_pkg::SYNC_RESET;
      syncPin_reg   <= cpsc_pkg::SYNC_RESET;
      ctrl_reg      <= cpsc_pkg::CTRL_RESET;
      intStatus_reg <= '0;
      intEnable_reg <= '0;
      losState_reg  <= 1'b0;
      prevLos_reg   <= 1'b0;
      prevAlign_reg <= 1'b0;
      prevDown_reg  <= 1'b0;
      pending_reg   <= 1'b0;
      txIdx_reg     <= 2'h0;
      rxIdx_reg     <= 2'h0;
      clkA_reg      <= 2'h1;
      clkB_reg      <= 2'h1;
      losPin_reg    <= 2'h1;
      hsTx_reg      <= 1'b0;
      lsOut_reg     <= '0;
      txAlign_reg   <= 1'b0;
      dpReset_reg   <= 1'b0;
      irq_reg       <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      syncMeta_reg  <= syncMeta_next;
      syncPin_reg   <= syncPin_next;
      ctrl_reg      <= ctrl_next;
      intStatus_reg <= intStatus_next;
      intEnable_reg <= intEnable_next;
      losState_reg  <= losState_next;
      prevLos_reg   <= prevLos_next;
      prevAlign_reg <= prevAlign_next;
      prevDown_reg  <= prevDown_next;
      pending_reg   <= pending_next;
      txIdx_reg     <= txIdx_next;
      rxIdx_reg     <= rxIdx_next;
      clkA_reg      <= clkA_next;
      clkB_reg      <= clkB_next;
      losPin_reg    <= losPin_next;
      hsTx_reg      <= hsTx_next;
      lsOut_reg     <= lsOut_next;
      txAlign_reg   <= txAlign_next;
      dpReset_reg   <= dpReset_next;
      irq_reg       <= irq_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign irq                 = irq_reg;
  assign chanAClockOutPair   = clkA_reg;
  assign chanBClockOutPair   = clkB_reg;
  assign hsSerialTxPos       = hsTx_reg;
  assign lsParallelOutLanes  = lsOut_reg;
  assign signalLostIndicator = losPin_reg;
  assign localTxAlignedOut   = txAlign_reg;
  assign datapathResetPulse  = dpReset_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_reset_outputs_zero: assert property (disable iff (1'b0) !rst_n |->
    !hsSerialTxPos && lsParallelOutLanes == '0 && !chanAClockOutPair.level && !chanBClockOutPair.level)
    else $error("outputs not zero during reset");
  a_clock_pair_float: assert property (bothDown |=> !chanAClockOutPair.drive && !chanBClockOutPair.drive)
    else $error("clock pairs driven with both channels down");
  a_route_a_to_b: assert property (!bothDown && ctrl_reg.routeAtoB |=>
    chanBClockOutPair.level == $past(syncPin_reg[cpsc_pkg::SYNC_CLK_A]))
    else $error("channel B clock pair does not follow channel A clock");
  a_partner_sync: assert property (##2 partnerAligned == $past(partnerRxAlignedIn, 2))
    else $error("partner alignment not seen two cycles later");
  a_tx_aligned_out: assert property (!chanDown |=> localTxAlignedOut == $past(txLanesAligned))
    else $error("transmit alignment output wrong");
  a_powerdown_quiet: assert property (chanDown |=> !hsSerialTxPos && lsParallelOutLanes == '0)
    else $error("datapath active in power-down");
  a_tx_lane_one: assert property (!chanDown && ctrl_reg.serRatio == cpsc_pkg::RATIO_1TO1 |=>
    hsSerialTxPos == $past(lsParallelInLanes[0]))
    else $error("1:1 transmit does not use lane 0 only");
  a_rx_lane_mask: assert property (ctrl_reg.serRatio == cpsc_pkg::RATIO_2TO1 |=> lsParallelOutLanes[3:2] == 2'h0)
    else $error("2:1 receive drives upper lanes");
  a_los_pin_state: assert property (!chanDown && ctrl_reg.losSelect == cpsc_pkg::LOSSEL_STATE |=>
    signalLostIndicator.level == $past(losState_reg))
    else $error("loss pin does not show loss state");
  a_los_hysteresis: assert property (ctrl_reg.losEnable && rxSwingMvpp >= cpsc_pkg::LOS_LOW_MVPP &&
    rxSwingMvpp <= cpsc_pkg::LOS_HIGH_MVPP |=> $stable(losState_reg))
    else $error("loss state moved between thresholds");
  a_los_assert_low: assert property (ctrl_reg.losEnable && rxSwingMvpp < cpsc_pkg::LOS_LOW_MVPP ##1
    !chanDown && ctrl_reg.losSelect == cpsc_pkg::LOSSEL_STATE |=> signalLostIndicator.level)
    else $error("loss pin not set two cycles after low swing");
  a_los_show_partner: assert property (!chanDown && ctrl_reg.losSelect == cpsc_pkg::LOSSEL_PARTNER |=>
    signalLostIndicator.level == $past(partnerAligned))
    else $error("loss pin does not show partner alignment");
  a_los_pin_float: assert property (chanDown |=> !signalLostIndicator.drive)
    else $error("loss pin driven in power-down");
  a_power_up_pending: assert property (prevDown_reg && !chanDown |=> pending_reg && intStatus_reg[3])
    else $error("power-up did not flag pending datapath reset");

  c_los_set:      cover property (losState_reg && !prevLos_reg);
  c_route_used:   cover property (ctrl_reg.routeAtoB && !bothDown);
  c_power_up:     cover property (prevDown_reg && !chanDown);
  c_dp_reset:     cover property (pending_reg ##1 datapathResetPulse);

endmodule : cpsc_channel_pin_status_control

// >>> verif/cpsc_partner_model.sv
// Link partner model that reports its receive lane alignment
`timescale 1ns/1ps
module cpsc_partner_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Bench control
  input  wire logic alignCmd,
  input  wire logic slowMode,
  // Status pin toward the device
  output logic      partnerRxAlignedIn
);
  logic [2:0] waitCnt;

  // A slow partner needs several cycles before its lanes settle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt            <= 3'h0;
      partnerRxAlignedIn <= 1'b0;
    end else if (alignCmd == partnerRxAlignedIn) begin
      waitCnt <= 3'h0;
    end else if (waitCnt >= (slowMode ? 3'h5 : 3'h0)) begin
      waitCnt            <= 3'h0;
      partnerRxAlignedIn <= alignCmd;
    end else begin
      waitCnt <= waitCnt + 3'h1;
    end
  end
endmodule : cpsc_partner_model

// >>> verif/tb_top.sv
// Self-checking testbench of the channel pin status control block
`timescale 1ns/1ps
module tb_top;
  logic                clock, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]          paddr, rxSwingMvpp;
  logic [31:0]         pwdata, prdata, q;
  logic                chanAPowerdownLow, chanBPowerdownLow, partnerRxAlignedIn;
  logic                chanAByteClock, chanBByteClock, hsSerialRxBit, txLanesAligned;
  logic [3:0]          lsParallelInLanes, lsParallelOutLanes, mask;
  logic                hsSerialTxPos, localTxAlignedOut, datapathResetPulse;
  logic                alignCmd, slowMode, e, v, losModel, hits;
  cpsc_pkg::cpsc_pin_t chanAClockOutPair, chanBClockOutPair, signalLostIndicator;
  logic [7:0]          sw;
  int                  n_errors = 0;
  int                  checks = 0;
  int                  pulses = 0;
  logic [7:0]          corner [8] = '{8'h4C, 8'h4B, 8'h4A, 8'h95, 8'h96, 8'h97, 8'h4B, 8'h4A};

  cpsc_channel_pin_status_control i_cpsc_channel_pin_status_control (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .chanAPowerdownLow(chanAPowerdownLow), .chanBPowerdownLow(chanBPowerdownLow),
    .partnerRxAlignedIn(partnerRxAlignedIn), .chanAByteClock(chanAByteClock), .chanBByteClock(chanBByteClock),
    .lsParallelInLanes(lsParallelInLanes), .hsSerialRxBit(hsSerialRxBit), .rxSwingMvpp(rxSwingMvpp),
    .txLanesAligned(txLanesAligned), .chanAClockOutPair(chanAClockOutPair),
    .chanBClockOutPair(chanBClockOutPair), .hsSerialTxPos(hsSerialTxPos),
    .lsParallelOutLanes(lsParallelOutLanes), .signalLostIndicator(signalLostIndicator),
    .localTxAlignedOut(localTxAlignedOut), .datapathResetPulse(datapathResetPulse));
  cpsc_partner_model i_cpsc_partner_model (.clock(clock), .rst_n(rst_n), .alignCmd(alignCmd),
    .slowMode(slowMode), .partnerRxAlignedIn(partnerRxAlignedIn));

  always #50 clock = ~clock;
  always @(posedge clock) if (datapathResetPulse === 1'b1) pulses++;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : cyc

  // Entered just after a rising edge; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", q & m, exp);
  endtask : rd

  function automatic logic [31:0] ctl(input logic [1:0] r, input logic [1:0] s, input logic [2:0] b);
    return {24'h0, r, s, 1'b1, b};
  endfunction : ctl

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0; rst_n = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; chanAPowerdownLow = 1'b1; chanBPowerdownLow = 1'b1; chanAByteClock = 1'b0;
    chanBByteClock = 1'b0; lsParallelInLanes = 4'h0; hsSerialRxBit = 1'b0; rxSwingMvpp = 8'hC8;
    txLanesAligned = 1'b0; alignCmd = 1'b0; slowMode = 1'b1; losModel = 1'b0;
    void'($urandom(32'hF544));
    // A real falling edge, so the asynchronous reset acts before the first clock
    rst_n <= 1'b0;
    cyc(2);
    chk("clock pair in reset", chanBClockOutPair, 32'h1);
    chk("loss pin in reset", signalLostIndicator, 32'h1);
    rst_n <= 1'b1;
    cyc(1);
    rd(cpsc_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h0C8);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped data", q, 32'h0);
    chk("unmapped error", e, 1'b1);
    apb(1'b1, cpsc_pkg::OFF_STATUS, 32'hFFFFFFFF);
    rd(cpsc_pkg::OFF_INT_CLEAR, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_PARTNER, 3'h0));
    for (int i = 0; i < 4; i++) begin
      alignCmd <= ~i[0];
      slowMode <= 1'($urandom);
      cyc(12);
      chk("partner on loss pin", signalLostIndicator.level, !i[0]);
      rd(cpsc_pkg::OFF_STATUS, 32'h2, {30'h0, ~i[0], 1'b0});
    end
    rd(cpsc_pkg::OFF_INT_STATUS, 32'h4, 32'h4);
    apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_LOCAL, 3'h0));
    for (int i = 0; i < 8; i++) begin
      v = 1'($urandom);
      txLanesAligned <= v;
      cyc(3);
      chk("tx aligned out", {localTxAlignedOut, signalLostIndicator.level}, {v, v});
    end
    apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_STATE, 3'h0));
    // Corner swings first, then random ones around both thresholds
    for (int i = 0; i < 40; i++) begin
      sw = (i < 8) ? corner[i] : 8'($urandom_range(60, 170));
      rxSwingMvpp <= sw;
      cyc(3);
      losModel = (sw < 8'd75) ? 1'b1 : ((sw > 8'd150) ? 1'b0 : losModel);
      chk("loss level", signalLostIndicator, {losModel, 1'b1});
    end
    apb(1'b1, cpsc_pkg::OFF_CTRL, 32'h0C0);
    rxSwingMvpp <= 8'h00;
    cyc(3);
    chk("loss disabled", signalLostIndicator.level, 32'h0);
    apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_STATE, 3'h0));
    rxSwingMvpp <= 8'hC8;
    cyc(3);
    apb(1'b1, cpsc_pkg::OFF_INT_CLEAR, 32'hF);
    rd(cpsc_pkg::OFF_INT_STATUS, 32'hF, 32'h0);
    apb(1'b1, cpsc_pkg::OFF_INT_ENABLE, 32'h1);
    rd(cpsc_pkg::OFF_INT_ENABLE, 32'hFFFFFFFF, 32'h1);
    rxSwingMvpp <= 8'h00;
    cyc(3);
    chk("irq on loss", irq, 32'h1);
    rd(cpsc_pkg::OFF_INT_STATUS, 32'hF, 32'h1);
    apb(1'b1, cpsc_pkg::OFF_INT_ENABLE, 32'h0);
    cyc(2);
    chk("irq masked", irq, 32'h0);
    apb(1'b1, cpsc_pkg::OFF_INT_ENABLE, 32'h1);
    apb(1'b1, cpsc_pkg::OFF_INT_CLEAR, 32'h1);
    cyc(2);
    chk("irq cleared", irq, 32'h0);
    rxSwingMvpp <= 8'hC8;
    chanAPowerdownLow <= 1'b0;
    lsParallelInLanes <= 4'hF;
    hsSerialRxBit <= 1'b1;
    cyc(5);
    chk("channel A down", {signalLostIndicator.drive, hsSerialTxPos, lsParallelOutLanes}, 32'h0);
    chk("pair one down", chanAClockOutPair.drive, 32'h1);
    chanBPowerdownLow <= 1'b0;
    cyc(5);
    chk("pairs both down", {chanAClockOutPair.drive, chanBClockOutPair.drive}, 32'h0);
    chanAPowerdownLow <= 1'b1;
    chanBPowerdownLow <= 1'b1;
    cyc(5);
    chk("pairs up", {chanAClockOutPair.drive, signalLostIndicator.drive}, 32'h3);
    rd(cpsc_pkg::OFF_INT_STATUS, 32'h8, 32'h8);
    apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_PENDING, 3'h0));
    cyc(2);
    chk("pending on loss pin", signalLostIndicator.level, 1'b1);
    apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_PENDING, 3'h0) | 32'h100);
    cyc(2);
    chk("datapath reset pulses", pulses, 32'h1);
    chk("pending cleared", signalLostIndicator.level, 1'b0);
    // Of the two register bits, only that of channel A floats the loss pin of channel A
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_STATE, 3'(i << 1)));
      cyc(3);
      chk("register down", {chanAClockOutPair.drive, signalLostIndicator.drive}, {i != 3, i == 2});
    end
    for (int r = 0; r < 3; r++) begin
      mask = (r == 0) ? 4'h1 : ((r == 1) ? 4'h3 : 4'hF);
      apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(2'(r), cpsc_pkg::LOSSEL_STATE, 3'h0));
      cyc(6);
      chk("rx lanes", lsParallelOutLanes, mask);
      for (int k = 0; k < 2; k++) begin
        // Second pass drives only the highest lane in use
        lsParallelInLanes <= (k == 0) ? ~mask : (mask ^ (mask >> 1));
        hits = 1'b0;
        cyc(2);
        repeat (8) begin
          @(posedge clock);
          hits = hits | hsSerialTxPos;
        end
        chk("tx lane use", hits, k);
      end
    end
    for (int i = 0; i < 8; i++) begin
      v = 1'($urandom);
      apb(1'b1, cpsc_pkg::OFF_CTRL, ctl(cpsc_pkg::RATIO_4TO1, cpsc_pkg::LOSSEL_STATE, {2'h0, i[0]}));
      chanAByteClock <= v;
      chanBByteClock <= ~v;
      cyc(4);
      chk("B clock pair", chanBClockOutPair.level, i[0] ? v : !v);
    end
    txLanesAligned <= 1'b1;
    cyc(3);
    rst_n <= 1'b0;
    #20;
    chk("outputs in reset", {chanAClockOutPair, chanBClockOutPair, signalLostIndicator, hsSerialTxPos,
      lsParallelOutLanes, localTxAlignedOut}, {6'h15, 6'h0});
    finish_test();
  end
endmodule : tb_top
